/* File: design/pudas_params.svh */
// timing counts, reset values and address prefixes of the power-up defaults loader
`ifndef PUDAS_PARAMS_SVH
`define PUDAS_PARAMS_SVH
`define PUDAS_CLK_HZ          40000000
`define PUDAS_RATE_FAST_HZ    8
`define PUDAS_RATE_SLOW_HZ    4
`define PUDAS_FAST_CYCLES     (`PUDAS_CLK_HZ / `PUDAS_RATE_FAST_HZ)
`define PUDAS_SLOW_CYCLES     (`PUDAS_CLK_HZ / `PUDAS_RATE_SLOW_HZ)
`define PUDAS_PTR_RST         8'h00
`define PUDAS_RATE_RST        8'h06
`define PUDAS_HYST_RST        8'h0a
`define PUDAS_HIGH_RST        8'h7f
`define PUDAS_LOW_RST         8'hc9
`define PUDAS_PFX_GND         4'h3
`define PUDAS_PFX_HIZ         4'h5
`define PUDAS_PFX_VCC         4'h9
`define PUDAS_SETTLE_CYCLES   4
`endif

/* File: design/pudas_pkg.sv */
// types shared by the power-up defaults loader
package pudas_pkg;
  typedef enum logic [1:0] {
    PUDAS_PIN_GND = 2'b00,
    PUDAS_PIN_HIZ = 2'b01,
    PUDAS_PIN_VCC = 2'b10
  } pudas_pin_t;

  typedef struct packed {
    logic [7:0] cmd_ptr;
    logic [7:0] conv_rate;
    logic [7:0] hyst;
    logic [7:0] high_temp_limit;
    logic [7:0] low_temp_limit;
  } pudas_regs_t;

  typedef struct packed {
    logic conv_local;
    logic conv_remote2;
    logic conv_remote1;
  } pudas_conv_t;
endpackage

/* File: design/pudas_strap_decode.sv */
// decodes the two three-level address straps into a 7-bit slave address
`timescale 1ns/1ps
`include "pudas_params.svh"
module pudas_strap_decode
  import pudas_pkg::*;
(
  input  wire pudas_pkg::pudas_pin_t addr_strap_first,
  input  wire pudas_pkg::pudas_pin_t addr_strap_second,
  output logic [6:0]                 addr
);
  logic [3:0] prefix;
  logic [2:0] low;

  always_comb
  begin
    // low bits step by the second strap; vcc prefix rows start at 100
    case (addr_strap_first)   // [R01]
      PUDAS_PIN_GND:
      begin
        prefix = `PUDAS_PFX_GND;
        low    = 3'h0;
      end
      PUDAS_PIN_HIZ:
      begin
        prefix = `PUDAS_PFX_HIZ;
        low    = 3'h1;
      end
      default:
      begin
        prefix = `PUDAS_PFX_VCC;
        low    = 3'h4;
      end
    endcase
    case (addr_strap_second)   // [R01]
      PUDAS_PIN_GND: addr = {prefix, low};
      PUDAS_PIN_HIZ: addr = {prefix, 3'(low + 3'h1)};
      default:       addr = {prefix, 3'(low + 3'h2)};
    endcase
  end
endmodule

/* File: design/pudas_loader.sv */
// power-up defaults loader: strap address latch, register defaults, autonomous conversion ticks
// Behaviour
// R01: address is prefix from first strap plus low bits from second strap.
// R02: straps sampled at power-up; decoded value becomes the slave address.
// R03: autonomous conversions after power-up: remote 2 and local 4Hz, remote 1 8Hz.
// R04: command pointer resets to 00h.
// R05: high limits load maximum default, low limits load minimum default.
// R06: hysteresis resets to ten degrees Celsius.
// R07: latched alert is cleared at power-up and reset.
// R08: straps sampled only at reset; later pin changes ignored.
// R09: external reset high restores all power-on values and resamples straps.
// R10: conversion rate register resets to 06h.
`timescale 1ns/1ps
`include "pudas_params.svh"
module pudas_loader
  import pudas_pkg::*;
#(
  parameter int FAST_CYCLES = `PUDAS_FAST_CYCLES,
  parameter int SLOW_CYCLES = `PUDAS_SLOW_CYCLES
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  ext_reset,
  input  wire pudas_pkg::pudas_pin_t addr_strap_first,
  input  wire pudas_pkg::pudas_pin_t addr_strap_second,
  input  wire logic                  alert_event,
  input  wire logic                  alert_clear,
  output logic [6:0]                 slave_addr,
  output logic                       addr_valid,
  output pudas_pkg::pudas_regs_t     regs,
  output logic                       alert_latched,
  output pudas_pkg::pudas_conv_t     conv_start
);
  import pudas_pkg::*;

  typedef enum logic [1:0] {
    PUDAS_ST_LOAD   = 2'b00,
    PUDAS_ST_SETTLE = 2'b01,
    PUDAS_ST_RUN    = 2'b10
  } pudas_state_t;

  // pins are asynchronous to ref_clk: two flops each before use
  logic [1:0] s1_first;
  logic [1:0] s2_first;
  logic [1:0] s1_second;
  logic [1:0] s2_second;
  logic       s1_ext;
  logic       s2_ext;

  always_ff @(posedge ref_clk)
  begin
    s1_first  <= addr_strap_first;
    s2_first  <= s1_first;
    s1_second <= addr_strap_second;
    s2_second <= s1_second;
    s1_ext    <= ext_reset;
    s2_ext    <= s1_ext;
  end

  logic [6:0] decoded;

  pudas_strap_decode u_dec (
    .addr_strap_first  (pudas_pin_t'(s2_first)),
    .addr_strap_second (pudas_pin_t'(s2_second)),
    .addr              (decoded)
  );

  pudas_state_t state;
  pudas_state_t next_state;
  logic [2:0]   settle;
  logic [2:0]   next_settle;
  logic [6:0]   next_slave_addr;
  logic         next_addr_valid;
  pudas_regs_t  next_regs;
  logic         next_alert_latched;
  logic [31:0]  fast_cnt;
  logic [31:0]  next_fast_cnt;
  logic [31:0]  slow_cnt;
  logic [31:0]  next_slow_cnt;
  pudas_conv_t  next_conv_start;
  logic         reload;

  assign reload = s2_ext;   // [R09]

  always_comb
  begin
    next_state         = state;
    next_settle        = settle;
    next_slave_addr    = slave_addr;
    next_addr_valid    = addr_valid;
    next_regs          = regs;
    next_alert_latched = alert_latched;
    next_fast_cnt      = fast_cnt;
    next_slow_cnt      = slow_cnt;
    next_conv_start    = '0;
    if (reload)
    begin
      // external reset behaves like power-up: defaults reloaded, straps resampled
      next_state                = PUDAS_ST_LOAD;   // [R09]
      next_addr_valid           = 1'b0;
      next_regs.cmd_ptr         = `PUDAS_PTR_RST;   // [R04]
      next_regs.conv_rate       = `PUDAS_RATE_RST;   // [R10]
      next_regs.hyst            = `PUDAS_HYST_RST;   // [R06]
      next_regs.high_temp_limit = `PUDAS_HIGH_RST;   // [R05]
      next_regs.low_temp_limit  = `PUDAS_LOW_RST;   // [R05]
      next_alert_latched        = 1'b0;   // [R07]
    end
    else
    begin
      case (state)
        PUDAS_ST_LOAD:
        begin
          // wait lets fresh pin values reach the synchroniser output
          next_settle = 3'h0;
          next_state  = PUDAS_ST_SETTLE;
        end
        PUDAS_ST_SETTLE:
        begin
          next_settle = 3'(settle + 3'h1);
          if (settle == 3'(`PUDAS_SETTLE_CYCLES - 1))
          begin
            next_slave_addr = decoded;   // [R02]
            next_addr_valid = 1'b1;
            next_fast_cnt   = '0;
            next_slow_cnt   = '0;
            next_state      = PUDAS_ST_RUN;
          end
        end
        PUDAS_ST_RUN:
        begin
          // address held here; pin changes no longer reach slave_addr [R08]
          next_fast_cnt = fast_cnt + 32'h1;
          next_slow_cnt = slow_cnt + 32'h1;
          if (fast_cnt == 32'(FAST_CYCLES - 1))
          begin
            next_fast_cnt                = '0;
            next_conv_start.conv_remote1 = 1'b1;   // [R03]
          end
          if (slow_cnt == 32'(SLOW_CYCLES - 1))
          begin
            next_slow_cnt                = '0;
            next_conv_start.conv_remote2 = 1'b1;   // [R03]
            next_conv_start.conv_local   = 1'b1;   // [R03]
          end
          // set wins over clear
          if (alert_clear)
            next_alert_latched = 1'b0;
          if (alert_event)
            next_alert_latched = 1'b1;
        end
        default:
          next_state = PUDAS_ST_LOAD;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state                <= PUDAS_ST_LOAD;
      settle               <= 3'h0;
      slave_addr           <= 7'h00;
      addr_valid           <= 1'b0;
      regs.cmd_ptr         <= `PUDAS_PTR_RST;   // [R04]
      regs.conv_rate       <= `PUDAS_RATE_RST;   // [R10]
      regs.hyst            <= `PUDAS_HYST_RST;   // [R06]
      regs.high_temp_limit <= `PUDAS_HIGH_RST;   // [R05]
      regs.low_temp_limit  <= `PUDAS_LOW_RST;   // [R05]
      alert_latched        <= 1'b0;   // [R07]
      fast_cnt             <= 32'h0;
      slow_cnt             <= 32'h0;
      conv_start           <= '0;
    end
    else
    begin
      state         <= next_state;
      settle        <= next_settle;
      slave_addr    <= next_slave_addr;
      addr_valid    <= next_addr_valid;
      regs          <= next_regs;
      alert_latched <= next_alert_latched;
      fast_cnt      <= next_fast_cnt;
      slow_cnt      <= next_slow_cnt;
      conv_start    <= next_conv_start;
    end
  end
endmodule

/* File: bench/pudas_strap_model.sv */
// board model of the two address strap pins
`timescale 1ns/1ps
module pudas_strap_model
  import pudas_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic [1:0]      sel_first,
  input  wire logic [1:0]      sel_second,
  output pudas_pkg::pudas_pin_t addr_strap_first,
  output pudas_pkg::pudas_pin_t addr_strap_second
);
  // straps follow the board one clock late, like a slow strap edge
  always_ff @(posedge ref_clk)
  begin
    addr_strap_first  <= pudas_pin_t'(sel_first);
    addr_strap_second <= pudas_pin_t'(sel_second);
  end
endmodule

/* File: bench/pudas_loader_checker.sv */
// assertions for the power-up defaults loader
`timescale 1ns/1ps
module pudas_loader_checker
  import pudas_pkg::*;
(
  input logic                  ref_clk,
  input logic                  rst_n,
  input logic                  ext_reset,
  input pudas_pkg::pudas_pin_t addr_strap_first,
  input pudas_pkg::pudas_pin_t addr_strap_second,
  input logic                  alert_event,
  input logic                  alert_clear,
  input logic [6:0]            slave_addr,
  input logic                  addr_valid,
  input pudas_pkg::pudas_regs_t regs,
  input logic                  alert_latched,
  input pudas_pkg::pudas_conv_t conv_start
);
  localparam pudas_regs_t DEF = {8'h00, 8'h06, 8'h0a, 8'h7f, 8'hc9};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  reset_defaults_a: assert property (disable iff (1'b0)
    !rst_n |=> regs == DEF && !alert_latched && !addr_valid)
    else $error("defaults missing");
  // one load cycle and four settle cycles pass before the address is latched
  valid_delay_a: assert property ($rose(rst_n) |-> !addr_valid[*5] ##1 addr_valid)
    else $error("address latch late");
  ext_reset_a: assert property ($rose(ext_reset) |-> ##3 (regs == DEF && !alert_latched))
    else $error("external reset ignored");
  addr_hold_a: assert property (addr_valid && $past(addr_valid) |-> $stable(slave_addr))
    else $error("address moved");
  conv_pulse_a: assert property (conv_start.conv_remote1 |=> !conv_start.conv_remote1)
    else $error("pulse too long");
  slow_sync_a: assert property (conv_start.conv_remote2 || conv_start.conv_local |-> conv_start == 3'h7)
    else $error("slow tick off phase");
  // the external reset reaches the logic two edges late and then clears the latch first
  alert_set_a: assert property (alert_event && addr_valid && !$past(ext_reset, 2) |=> alert_latched)
    else $error("alert not set");
  alert_clear_a: assert property (alert_clear && !alert_event && addr_valid |=> !alert_latched)
    else $error("alert not cleared");
  cover property ($rose(addr_valid));
  cover property (conv_start.conv_remote2);
  cover property (alert_latched ##1 !alert_latched);
endmodule
bind pudas_loader pudas_loader_checker u_chk (
  .ref_clk           (ref_clk),
  .rst_n             (rst_n),
  .ext_reset         (ext_reset),
  .addr_strap_first  (addr_strap_first),
  .addr_strap_second (addr_strap_second),
  .alert_event       (alert_event),
  .alert_clear       (alert_clear),
  .slave_addr        (slave_addr),
  .addr_valid        (addr_valid),
  .regs              (regs),
  .alert_latched     (alert_latched),
  .conv_start        (conv_start)
);

/* File: bench/tb_top.sv */
// self-checking bench for the power-up defaults loader
`timescale 1ns/1ps
module tb_top;
  import pudas_pkg::*;
  localparam int F = 8;
  logic ref_clk = 0, rst_n = 0, ext_reset = 0, alert_event = 0, alert_clear = 0;
  logic [1:0] sf = 0, ss = 0;
  logic [31:0] seed = 32'h9fba;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  pudas_pin_t pf, ps;
  logic [6:0] slave_addr;
  logic addr_valid, alert_latched;
  pudas_regs_t regs;
  pudas_conv_t conv_start;
  always #12.5 ref_clk = ~ref_clk;
  pudas_strap_model u_pudas_strap_model (.ref_clk(ref_clk), .sel_first(sf), .sel_second(ss),
    .addr_strap_first(pf), .addr_strap_second(ps));
  pudas_loader #(.FAST_CYCLES(F), .SLOW_CYCLES(2 * F)) u_pudas_loader (.ref_clk(ref_clk), .rst_n(rst_n),
    .ext_reset(ext_reset), .addr_strap_first(pf), .addr_strap_second(ps), .alert_event(alert_event),
    .alert_clear(alert_clear), .slave_addr(slave_addr), .addr_valid(addr_valid), .regs(regs),
    .alert_latched(alert_latched), .conv_start(conv_start));
  function automatic logic [1:0] rnd3();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return 2'(seed % 3);
  endfunction
  // expected address per strap pair, written out as a table rather than the decoder's arithmetic
  function automatic logic [6:0] exp_addr(logic [1:0] f, logic [1:0] s);
    logic [6:0] a;
    case ({f, s})
      4'h0:    a = 7'h18;
      4'h1:    a = 7'h19;
      4'h2:    a = 7'h1a;
      4'h4:    a = 7'h29;
      4'h5:    a = 7'h2a;
      4'h6:    a = 7'h2b;
      4'h8:    a = 7'h4c;
      4'h9:    a = 7'h4d;
      default: a = 7'h4e;
    endcase
    return a;
  endfunction
  task automatic chk(string what, logic [39:0] exp, logic [39:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(logic e, logic c);
    @(posedge ref_clk);
    alert_event <= e;
    alert_clear <= c;
    @(posedge ref_clk);
    alert_event <= 1'b0;
    alert_clear <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      error_cnt++;
      summarize();
    end
  end
  initial
  begin
    int n, r1, r2, r3;
    logic [1:0] a, b;
    repeat (10) @(posedge ref_clk);
    for (int i = 0; i < 9; i++)
    begin
      @(posedge ref_clk);
      a = 2'(i / 3);
      b = 2'(i % 3);
      sf <= a;
      ss <= b;
      rst_n <= 1'b0;
      @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (9) @(negedge ref_clk);
      chk("addr", exp_addr(a, b), slave_addr);
      chk("regs", {8'h00, 8'h06, 8'h0a, 8'h7f, 8'hc9}, regs);
      chk("alert", 0, alert_latched);
      @(posedge ref_clk);
      sf <= rnd3();
      ss <= rnd3();
      repeat (6) @(negedge ref_clk);
      chk("held", exp_addr(a, b), slave_addr);
      $display("strap test %0d done", i);
    end
    n = 0;
    while (conv_start.conv_remote1 !== 1'b1 && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    r1 = 0;
    r2 = 0;
    r3 = 0;
    repeat (8 * F)
    begin
      @(negedge ref_clk);
      r1 += int'(conv_start.conv_remote1);
      r2 += int'(conv_start.conv_local);
      r3 += int'(conv_start.conv_remote2);
    end
    chk("fast", 8, r1);
    chk("slow", 4, r2);
    chk("slow2", 4, r3);
    $display("conversion test done");
    pulse(1'b1, 1'b1);
    chk("set", 1, alert_latched);
    pulse(1'b0, 1'b1);
    chk("clr", 0, alert_latched);
    pulse(1'b1, 1'b0);
    a = rnd3();
    b = rnd3();
    @(posedge ref_clk);
    sf <= a;
    ss <= b;
    ext_reset <= 1'b1;
    repeat (6) @(posedge ref_clk);
    ext_reset <= 1'b0;
    repeat (12) @(negedge ref_clk);
    chk("ext", exp_addr(a, b), slave_addr);
    chk("ealert", 0, alert_latched);
    $display("alert and reset test done");
    summarize();
  end
endmodule
